// ---- hw/strap_pkg.sv ----
// package for the strap and sideband pin control block
// assumes one 10 MHz clock and a synchronous active-low reset
// Notes on behaviour
// - eeprom data pin sampled as eeprom enable
// - drive eeprom clock; data pin bidirectional after init
// - scan enable pin drives zero normally
// - eight general pins, per-pin output enable
// - general pins 7:5 give bus address 2:0
// - debug mode: general pins 4:0 select debug
// - power saving follows power saving strap
// - select strap: low substate, high status
// - protocol strap low i2c, high smbus
// - refclk request active low, controls substate
// - status mode drives port status per port
package strap_pkg;
  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int         GP_W          = 8;     // general pin count
  localparam int         PORTS         = 4;     // per-port pin count
  localparam int         ADDR_LO       = 5;     // address bits low index
  localparam int         ADDR_W        = 3;     // address bits taken
  localparam int         DBG_W         = 5;     // debug select width
  localparam logic       SCAN_OUT_VAL  = 1'h0;  // scan pin level
  localparam logic [7:0] GP_OE_RST     = 8'h00; // all inputs at reset
  localparam logic [7:0] GP_OUT_RST    = 8'h00;
  // pull defaults for undriven straps
  localparam logic EE_EN_DEF   = 1'h1;
  localparam logic PSAV_DEF    = 1'h1;
  localparam logic SEL_DEF     = 1'h0;
  localparam logic PROTO_DEF   = 1'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,   // held in reset
    ST_CAPT  = 2'b01,   // straps captured, eeprom and port pins still off
    ST_RUN   = 2'b10    // normal operation
  } init_state_e;

  typedef struct packed {
    logic eeprom_enable;   // eeprom loading on
    logic power_saving;    // power saving on
    logic status_mode;     // 1 status, 0 substate
    logic smbus_mode;      // 1 smbus, 0 i2c
  } strap_s;
endpackage

// ---- hw/strap_sync_bit.sv ----
// one strap latch: captures a level on a capture strobe
// assumes the strobe is a one-cycle pulse in the system clock domain
module strap_sync_bit #(
  parameter logic DEF = 1'h0     // pull-level default
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // capture
  input  wire logic capture_i,
  input  wire logic level_i,
  output logic      held_o
);
  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  // reset loads the pull default; capture takes the pin
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      held_o <= DEF;
    end else if (capture_i) begin
      held_o <= level_i;
    end
  end
endmodule // strap_sync_bit

// ---- hw/strap_sideband_ctrl.sv ----
// strap and sideband pin control: straps, eeprom pins, scan pin,
// general pins and shared per-port pins
// assumes pins are synchronous to sys_clk_i; pad logic is outside
module strap_sideband_ctrl (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       resetn_i,
  // strap pins
  input  wire logic                       power_saving_strap_i,
  input  wire logic                       status_or_substate_select_i,
  input  wire logic                       mgmt_protocol_select_i,
  input  wire logic                       debug_mode_i,
  // eeprom pins
  input  wire logic                       eeprom_clk_gen_i,
  input  wire logic                       eeprom_data_out_i,
  input  wire logic                       eeprom_data_drive_i,
  input  wire logic                       eeprom_serial_data_i,
  output logic                            eeprom_serial_clock_o,
  output logic                            eeprom_serial_data_o,
  output logic                            eeprom_serial_data_oe_o,
  output logic                            eeprom_data_in_o,
  // scan pin
  input  wire logic                       manuf_test_i,
  input  wire logic                       full_scan_control_i,
  output logic                            full_scan_control_o,
  output logic                            full_scan_control_oe_o,
  output logic                            scan_in_o,
  // general pins
  input  wire logic [strap_pkg::GP_W-1:0] gp_oe_ctrl_i,
  input  wire logic [strap_pkg::GP_W-1:0] gp_out_ctrl_i,
  input  wire logic [strap_pkg::GP_W-1:0] general_pins_i,
  output logic [strap_pkg::GP_W-1:0]      general_pins_o,
  output logic [strap_pkg::GP_W-1:0]      general_pins_oe_o,
  output logic [strap_pkg::GP_W-1:0]      gp_in_o,
  output logic [strap_pkg::ADDR_W-1:0]    mgmt_addr_low_o,
  output logic [strap_pkg::DBG_W-1:0]     debug_select_o,
  // shared per-port pins
  input  wire logic [strap_pkg::PORTS-1:0] refclk_req_core_i,
  input  wire logic [strap_pkg::PORTS-1:0] port_status_i,
  output logic [strap_pkg::PORTS-1:0]      port_pins_o,
  output logic [strap_pkg::PORTS-1:0]      port_pins_oe_o,
  // captured strap outputs
  output strap_pkg::strap_s                straps_o,
  output logic                             init_done_o
);
  // ----------------------------------------------------------------
  // init sequencer
  // ----------------------------------------------------------------
  strap_pkg::init_state_e state_reg;   // sequencer state
  strap_pkg::init_state_e state_next;
  logic                   capture;     // one-cycle capture strobe

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      strap_pkg::ST_RESET: state_next = strap_pkg::ST_CAPT;
      strap_pkg::ST_CAPT:  state_next = strap_pkg::ST_RUN;
      strap_pkg::ST_RUN:   state_next = strap_pkg::ST_RUN;
      default:             state_next = strap_pkg::ST_RESET;
    endcase
  end

  // straps sampled in the first cycle after release, never later
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_reg <= strap_pkg::ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign capture = (state_reg == strap_pkg::ST_RESET);

  // ----------------------------------------------------------------
  // strap latches
  // ----------------------------------------------------------------
  strap_pkg::strap_s held;        // latched straps
  logic              ee_held;     // one latch output per strap
  logic              psav_held;
  logic              sel_held;
  logic              proto_held;

  // the struct gets a single driver; per-field port drivers would
  // leave one variable with four writers
  assign held = {ee_held, psav_held, sel_held, proto_held};

  // the eeprom data pin doubles as the enable strap; the pad is not
  // driven before capture, so its level is the board strap
  strap_sync_bit #(.DEF(strap_pkg::EE_EN_DEF)) u_ee (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .capture_i (capture),
    .level_i   (eeprom_serial_data_i),
    .held_o    (ee_held)
  );
  strap_sync_bit #(.DEF(strap_pkg::PSAV_DEF)) u_psav (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .capture_i (capture),
    .level_i   (power_saving_strap_i),
    .held_o    (psav_held)
  );
  strap_sync_bit #(.DEF(strap_pkg::SEL_DEF)) u_sel (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .capture_i (capture),
    .level_i   (status_or_substate_select_i),
    .held_o    (sel_held)
  );
  strap_sync_bit #(.DEF(strap_pkg::PROTO_DEF)) u_proto (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .capture_i (capture),
    .level_i   (mgmt_protocol_select_i),
    .held_o    (proto_held)
  );

  // ----------------------------------------------------------------
  // registered straps and init flag
  // ----------------------------------------------------------------
  logic run;   // eeprom and port pins live only after capture
  assign run = (state_reg == strap_pkg::ST_RUN);

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      straps_o    <= '0;
      init_done_o <= 1'h0;
    end else begin
      straps_o    <= held;
      init_done_o <= run;
    end
  end

  // ----------------------------------------------------------------
  // eeprom pins
  // ----------------------------------------------------------------
  // data pin is released while the strap is sampled
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      eeprom_serial_clock_o   <= 1'h0;
      eeprom_serial_data_o    <= 1'h0;
      eeprom_serial_data_oe_o <= 1'h0;
      eeprom_data_in_o        <= 1'h0;
    end else begin
      eeprom_serial_clock_o   <= run & eeprom_clk_gen_i;
      eeprom_serial_data_o    <= eeprom_data_out_i;
      eeprom_serial_data_oe_o <= run & eeprom_data_drive_i;
      eeprom_data_in_o        <= eeprom_serial_data_i;
    end
  end

  // ----------------------------------------------------------------
  // scan pin
  // ----------------------------------------------------------------
  // outside test the pin is an output held at zero
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      full_scan_control_o    <= strap_pkg::SCAN_OUT_VAL;
      full_scan_control_oe_o <= 1'h1;
      scan_in_o              <= 1'h0;
    end else begin
      full_scan_control_o    <= strap_pkg::SCAN_OUT_VAL;
      full_scan_control_oe_o <= ~manuf_test_i;
      scan_in_o              <= manuf_test_i & full_scan_control_i;
    end
  end

  // ----------------------------------------------------------------
  // general pins
  // ----------------------------------------------------------------
  // in debug mode the select bits are forced to inputs so the board
  // straps cannot be fought by software
  logic [strap_pkg::GP_W-1:0] dbg_mask;
  assign dbg_mask = debug_mode_i ?
                    {{(strap_pkg::GP_W-strap_pkg::DBG_W){1'h1}},
                     {strap_pkg::DBG_W{1'h0}}} :
                    {strap_pkg::GP_W{1'h1}};

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      general_pins_o    <= strap_pkg::GP_OUT_RST;
      general_pins_oe_o <= strap_pkg::GP_OE_RST;
      gp_in_o           <= '0;
      mgmt_addr_low_o   <= '0;
      debug_select_o    <= '0;
    end else begin
      general_pins_o    <= gp_out_ctrl_i;
      general_pins_oe_o <= gp_oe_ctrl_i & dbg_mask;
      gp_in_o           <= general_pins_i;
      mgmt_addr_low_o   <= general_pins_i[strap_pkg::ADDR_LO +:
                                          strap_pkg::ADDR_W];
      debug_select_o    <= debug_mode_i ?
                           general_pins_i[strap_pkg::DBG_W-1:0] :
                           '0;
    end
  end

  // ----------------------------------------------------------------
  // shared per-port pins
  // ----------------------------------------------------------------
  // substate mode: active-low clock request; status mode: port status
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      port_pins_o    <= '0;
      port_pins_oe_o <= '0;
    end else if (!run) begin
      port_pins_o    <= '0;
      port_pins_oe_o <= '0;
    end else if (held.status_mode) begin
      port_pins_o    <= port_status_i;
      port_pins_oe_o <= '1;
    end else begin
      port_pins_o    <= ~refclk_req_core_i;
      port_pins_oe_o <= '1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // the release edge still samples reset low and reloads the pull
  // defaults, so attempts on that edge are left out
  a_ee_strap_capt: assert property (
    capture && resetn_i |=>
      held.eeprom_enable == $past(eeprom_serial_data_i))
    else $error("eeprom enable strap not captured");
  a_straps_hold: assert property (
    run && $past(run) |-> $stable(held))
    else $error("strap changed after capture");
  a_ee_quiet_init: assert property (
    !run |=> !eeprom_serial_data_oe_o && !eeprom_serial_clock_o)
    else $error("eeprom pins driven before init");
  a_scan_zero: assert property (
    !manuf_test_i |=> full_scan_control_oe_o && !full_scan_control_o)
    else $error("scan pin not driven low");
  a_gp_oe_follow: assert property (
    resetn_i && !debug_mode_i |=>
      general_pins_oe_o == $past(gp_oe_ctrl_i))
    else $error("general pin enable mismatch");
  a_addr_bits: assert property (
    resetn_i |=> mgmt_addr_low_o == $past(general_pins_i[7:5]))
    else $error("address bits wrong");
  a_dbg_select: assert property (
    resetn_i && debug_mode_i |=>
      debug_select_o == $past(general_pins_i[4:0])
      && general_pins_oe_o[4:0] == 5'h00)
    else $error("debug select wrong");
  a_psav_out: assert property (
    run ##1 run |-> straps_o.power_saving == $past(held.power_saving))
    else $error("power saving output wrong");
  a_port_status: assert property (
    run && held.status_mode |=> port_pins_o == $past(port_status_i))
    else $error("port status not shown");
  a_refclk_low: assert property (
    run && !held.status_mode |=> port_pins_o == ~$past(refclk_req_core_i))
    else $error("clock request polarity wrong");
  a_proto_out: assert property (
    run ##1 run |-> straps_o.smbus_mode == $past(held.smbus_mode))
    else $error("protocol select wrong");

  c_status_mode: cover property (run && held.status_mode);
  c_substate:    cover property (run && !held.status_mode);
  c_debug:       cover property (debug_mode_i ##1 debug_select_o != '0);
  c_ee_off:      cover property (run && !held.eeprom_enable);
endmodule // strap_sideband_ctrl

// ---- bench/eeprom_model.sv ----
// partner model: serial eeprom on the shared data line
// assumes the line has a pull-up and the switch side drives first
module eeprom_model (
  // drive request from the bench acting as the eeprom
  input  wire logic drive_i,
  input  wire logic bit_i,
  // switch side of the line
  input  wire logic host_oe_i,
  input  wire logic host_data_i,
  // resolved line level
  output logic      pad_o,
  // management host lines
  output logic      mgmt_bus_clock_o,
  output logic      mgmt_bus_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // the eeprom drives the strap level in reset and data later;
  // a released line floats to the pull-up, never the last value
  assign pad_o = host_oe_i ? host_data_i :
                 (drive_i ? bit_i : 1'h1);
  // the host owns bus clock and data; no transfer is in scope here,
  // so an idle host leaves both lines at the pull-up level
  assign mgmt_bus_clock_o = 1'h1;
  assign mgmt_bus_data_o  = 1'h1;
endmodule // eeprom_model

// ---- bench/strap_and_sideband_pin_control_tb.sv ----
// self-checking bench for the strap and sideband pin control block
// assumes a 10 MHz clock and pads resolved here from all enables
module strap_and_sideband_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk_i = 0, resetn_i = 0;       // clock, reset
  logic psav = 0, sel = 0, proto = 0;      // strap levels
  logic dbg = 0, ck = 0, dout = 0, ddrv = 0; // debug, eeprom engine
  logic edrv = 0, ebit = 0, mt = 0, fsc = 0; // eeprom side, scan pad
  logic [7:0] goe = 0, gout = 0, gext = 0; // general pins
  logic [3:0] req = 0, pst = 0;            // per-port inputs
  logic ee_pad, ee_clk, ee_do, ee_oe, ee_in, f_o, f_oe, s_in, idone;
  logic [7:0] gp_o, gp_oe, gp_in, gp_pad;
  logic [2:0] addr;
  logic [4:0] dsel;
  logic [3:0] pp, pp_oe;
  logic mclk, mdat;                        // management host lines
  logic [3:0] cur_s;                       // straps of the last reset
  strap_pkg::strap_s straps;
  logic [46:0] q[$];                       // expected pin vectors
  logic [46:0] e;
  logic pddrv, pdout, pmt;                 // last cycle's inputs
  logic [7:0] pgoe, pgout, gpad_x;
  int failures = 0, samples_checked = 0, cyc = 0;
  integer seed = 32'h2B42;
  logic [31:0] r1, r2;
  // pads: whoever enables drives, else the outside level
  assign gp_pad = (gp_oe & gp_o) | (~gp_oe & gext);
  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  strap_sideband_ctrl u_strap_sideband_ctrl (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .power_saving_strap_i(psav), .status_or_substate_select_i(sel),
    .mgmt_protocol_select_i(proto), .debug_mode_i(dbg),
    .eeprom_clk_gen_i(ck), .eeprom_data_out_i(dout),
    .eeprom_data_drive_i(ddrv), .eeprom_serial_data_i(ee_pad),
    .eeprom_serial_clock_o(ee_clk), .eeprom_serial_data_o(ee_do),
    .eeprom_serial_data_oe_o(ee_oe), .eeprom_data_in_o(ee_in),
    .manuf_test_i(mt), .full_scan_control_i(f_oe ? f_o : fsc),
    .full_scan_control_o(f_o), .full_scan_control_oe_o(f_oe),
    .scan_in_o(s_in), .gp_oe_ctrl_i(goe), .gp_out_ctrl_i(gout),
    .general_pins_i(gp_pad), .general_pins_o(gp_o),
    .general_pins_oe_o(gp_oe), .gp_in_o(gp_in),
    .mgmt_addr_low_o(addr), .debug_select_o(dsel),
    .refclk_req_core_i(req), .port_status_i(pst),
    .port_pins_o(pp), .port_pins_oe_o(pp_oe),
    .straps_o(straps), .init_done_o(idone));
  eeprom_model u_eeprom_model (.drive_i(edrv), .bit_i(ebit),
    .host_oe_i(ee_oe), .host_data_i(ee_do), .pad_o(ee_pad),
    .mgmt_bus_clock_o(mclk), .mgmt_bus_data_o(mdat));
  // ----------------------------------------------------------------
  // clock, timeout, checking
  // ----------------------------------------------------------------
  always #50 sys_clk_i = ~sys_clk_i;       // 100 ns period
  // a hang ends the run as a mismatch
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input logic [46:0] g, x, input string m);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask
  // results land one edge after their inputs, so keep one note back
  always @(negedge sys_clk_i) begin
    if (q.size() > 1) begin
      e = q.pop_front();
      chk({ee_clk, ee_do, ee_oe, ee_in, f_o, f_oe, s_in, gp_o, gp_oe,
           gp_in, addr, dsel, pp, pp_oe},
          e, "pins");
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // reset with straps {eeprom, power save, select, protocol}
  // ----------------------------------------------------------------
  task automatic rst(input logic [3:0] s);
    @(posedge sys_clk_i);
    q.delete();
    {dbg, ck, dout, ddrv, mt, fsc, goe, gout, gext, req, pst} <= '0;
    {pddrv, pdout, pmt, pgoe, pgout} = '0;
    resetn_i <= 0;
    edrv <= 1;                             // eeprom holds strap level
    {ebit, psav, sel, proto} <= s;
    cur_s = s;
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({f_oe, ee_clk, idone}, 3'h4, "reset levels");
    chk({mclk, mdat}, 2'h3, "host lines idle");
    @(posedge sys_clk_i) resetn_i <= 1;
    repeat (2) @(posedge sys_clk_i);
    {ebit, psav, sel, proto} <= ~s;        // late change must be ignored
    @(negedge sys_clk_i) chk(idone, 0, "init early");
    @(negedge sys_clk_i);
    chk({idone, straps}, {1'h1, s}, "straps");
    $display("test reset with straps %h done", s);
  endtask
  // random traffic on every pin; straps wander too
  task automatic run(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      r1 = $random(seed);
      r2 = $random(seed);
      {dbg, fsc, mt, ebit, edrv, ddrv, dout, ck} <= r1[7:0];
      {gout, goe, gext, req, pst} <= {r1[23:8], r2[15:0]};
      {psav, sel, proto} <= r2[18:16];
      gpad_x = (pgoe & pgout) | (~pgoe & r2[15:8]);
      q.push_back({r1[0], r1[1], r1[2],
        pddrv ? pdout : (r1[3] ? r1[4] : 1'h1), 1'h0, ~r1[5],
        r1[5] & pmt & r1[6], r1[23:16],
        r1[7] ? {r1[15:13], 5'h00} : r1[15:8], gpad_x, gpad_x[7:5],
        r1[7] ? gpad_x[4:0] : 5'h00,
        cur_s[1] ? r2[3:0] : ~r2[7:4], 4'hF});
      {pddrv, pdout, pmt, pgout} = {r1[2], r1[1], r1[5], r1[23:16]};
      pgoe = r1[7] ? {r1[15:13], 5'h00} : r1[15:8];
    end
    @(negedge sys_clk_i);
    chk(straps, cur_s, "straps held in traffic");
    $display("test random traffic done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst(4'hA);
    run(300);
    rst(4'h5);
    run(300);
    chk(straps, 4'h5, "straps held");
    print_verdict();
  end
endmodule // strap_and_sideband_pin_control_tb
